// ==== rtl/olu_defs.svh ====
// Purpose: Constants for the output logic and delay unit.
// Assumes: 200 MHz clock; delays are held in tenths of a second.
// Notes: Register offsets are byte addresses on the APB bus.
`ifndef OLU_DEFS_SVH
`define OLU_DEFS_SVH

// ============================================================
// Register map
`define OLU_ADDR_W 8
`define OLU_REG_LOGIC 8'h00
`define OLU_REG_ROUTE 8'h04
`define OLU_REG_DLY0 8'h08
`define OLU_REG_STATUS 8'h20
`define OLU_DLY_REGS 6

// ============================================================
// Field layout
`define OLU_SEL_W 4
`define OLU_SEL_A_LSB 0
`define OLU_SEL_B_LSB 4
`define OLU_OP_LSB 8
`define OLU_TRIPM_LSB 10
`define OLU_DLY_W 10
`define OLU_NUM_FUNC 9
`define OLU_SRC_LOG 4'h9
`define OLU_NUM_OUT 3

// ============================================================
// Reset values
`define OLU_SEL_A_RST 4'h0
`define OLU_SEL_B_RST 4'h1
`define OLU_OP_RST 2'h0
`define OLU_TRIPM_RST 2'h0
`define OLU_ROUTE_RST 12'h000
`define OLU_DLY_RST 10'h000
`define OLU_DLY_MAX 10'h3E8

// ============================================================
// Timing
`define OLU_CLK_PERIOD_NS 5
`define OLU_TICK_TIME_NS 100000000
`define OLU_HOLD_TIME_DS 10
`define OLU_CNT_W 25

`endif

// ==== rtl/olu_pkg.sv ====
// Purpose: Types shared by the output logic and delay unit.
// Assumes: Nothing beyond the constants header.
// Notes: States are one-hot.
`default_nettype none
package olu_pkg;
    typedef enum logic [1:0] {
        OLU_OP_AND = 2'h0,
        OLU_OP_OR = 2'h1,
        OLU_OP_XOR = 2'h2
    } olu_op_t;
    typedef enum logic [3:0] {
        OLU_ST_OFF = 4'h1,
        OLU_ST_WAIT_ON = 4'h2,
        OLU_ST_ON = 4'h4,
        OLU_ST_WAIT_OFF = 4'h8
    } olu_dly_st_t;
endpackage
`default_nettype wire

// ==== rtl/olu_dly_if.sv ====
// Purpose: Carries one output channel between the top and its delay stage.
// Assumes: One instance per output.
// Notes: The control side drives everything but the delayed level.
`default_nettype none
`include "olu_defs.svh"
interface olu_dly_if;
    logic src;
    logic force_off;
    logic [`OLU_DLY_W-1:0] on_dly;
    logic [`OLU_DLY_W-1:0] off_dly;
    logic tick;
    logic out;
    modport ctl (output src, force_off, on_dly, off_dly, tick, input out);
    modport dly (input src, force_off, on_dly, off_dly, tick, output out);
endinterface
`default_nettype wire

// ==== rtl/olu_tick.sv ====
// Purpose: Produces a one-cycle pulse every tenth of a second.
// Assumes: TICK_CYCLES is at least two.
// Notes: Simulation may shorten TICK_CYCLES.
`default_nettype none
`include "olu_defs.svh"
module olu_tick #(
    parameter logic [`OLU_CNT_W-1:0] TICK_CYCLES = `OLU_CNT_W'(
        `OLU_TICK_TIME_NS / `OLU_CLK_PERIOD_NS)
) (
    // Clock and control
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Tick
    output logic tick_out
);
    logic [`OLU_CNT_W-1:0] cnt_q;
    wire last_w = (cnt_q == TICK_CYCLES - `OLU_CNT_W'(1));

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cnt_q <= '0;
        end else if (ce_in) begin
            cnt_q <= last_w ? '0 : cnt_q + `OLU_CNT_W'(1);
        end
    end

    assign tick_out = last_w & ce_in;
endmodule // olu_tick
`default_nettype wire

// ==== rtl/olu_delay.sv ====
// Purpose: Applies on and off delays to one output.
// Assumes: Delays count in ticks of a tenth of a second.
// Notes: The first tick of a wait may be partial, so a wait is
// accurate to within one tick.
`default_nettype none
`include "olu_defs.svh"
module olu_delay (
    // Clock and control
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Channel
    olu_dly_if.dly ch
);
    olu_pkg::olu_dly_st_t st_q, st_d;
    logic [`OLU_DLY_W-1:0] cnt_q, cnt_d;

    // A trip clear turns the target off; a nonzero off delay is
    // replaced by the fixed one-second hold.
    wire want_w = ch.src & ~ch.force_off;
    wire hold_w = ch.force_off & (ch.off_dly != `OLU_DLY_RST);
    wire [`OLU_DLY_W-1:0] offd_w = hold_w ?
        `OLU_DLY_W'(`OLU_HOLD_TIME_DS) : ch.off_dly;
    wire cnt_done_w = ch.tick &
        (cnt_q + `OLU_DLY_W'(1) >= (want_w ? ch.on_dly : offd_w));

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            olu_pkg::OLU_ST_OFF: begin
                cnt_d = '0;
                if (want_w) begin
                    st_d = (ch.on_dly == `OLU_DLY_RST) ?
                        olu_pkg::OLU_ST_ON : olu_pkg::OLU_ST_WAIT_ON;
                end
            end
            olu_pkg::OLU_ST_WAIT_ON: begin
                if (!want_w) begin
                    st_d = olu_pkg::OLU_ST_OFF;
                end else if (cnt_done_w) begin
                    st_d = olu_pkg::OLU_ST_ON;
                end else if (ch.tick) begin
                    cnt_d = cnt_q + `OLU_DLY_W'(1);
                end
            end
            olu_pkg::OLU_ST_ON: begin
                cnt_d = '0;
                if (!want_w) begin
                    st_d = (offd_w == `OLU_DLY_RST) ?
                        olu_pkg::OLU_ST_OFF : olu_pkg::OLU_ST_WAIT_OFF;
                end
            end
            olu_pkg::OLU_ST_WAIT_OFF: begin
                if (want_w) begin
                    st_d = olu_pkg::OLU_ST_ON;
                end else if (cnt_done_w) begin
                    st_d = olu_pkg::OLU_ST_OFF;
                end else if (ch.tick) begin
                    cnt_d = cnt_q + `OLU_DLY_W'(1);
                end
            end
            default: begin
                st_d = olu_pkg::OLU_ST_OFF;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st_q <= olu_pkg::OLU_ST_OFF;
            cnt_q <= '0;
        end else if (ce_in) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign ch.out = (st_q == olu_pkg::OLU_ST_ON) |
        (st_q == olu_pkg::OLU_ST_WAIT_OFF);
endmodule // olu_delay
`default_nettype wire

// ==== rtl/olu_top.sv ====
// Purpose: Logic output combiner, output routing, on/off delays and
// trip clear handling, configured over APB.
// Assumes: Function flags and run state are synchronous to the clock.
// Notes: APB answers with no wait states.
`default_nettype none
`include "olu_defs.svh"
module olu_top #(
    parameter logic [`OLU_CNT_W-1:0] TICK_CYCLES = `OLU_CNT_W'(
        `OLU_TICK_TIME_NS / `OLU_CLK_PERIOD_NS)
) (
    // Clock and control
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [`OLU_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Drive state
    input wire logic [`OLU_NUM_FUNC-1:0] func_flags_in,
    input wire logic run_active_in,
    input wire logic trip_clear_input_in,
    // Outputs
    output logic [`OLU_NUM_OUT-1:0] term_out,
    output logic log_out,
    output logic motor_off_out,
    output logic trip_cancel_out,
    output logic drive_stop_out
);
    // ============================================================
    // Configuration registers
    logic [`OLU_SEL_W-1:0] sel_a_q;
    logic [`OLU_SEL_W-1:0] sel_b_q;
    logic [1:0] op_q;
    logic [1:0] tripm_q;
    logic [3*`OLU_SEL_W-1:0] route_q;
    logic [`OLU_DLY_W-1:0] dly_q [`OLU_DLY_REGS];
    logic [31:0] prdata_q;

    // ============================================================
    // APB decode
    wire setup_w = psel_in & ~penable_in;
    wire wr_w = psel_in & penable_in & pwrite_in & ce_in;
    wire hit_logic_w = (paddr_in == `OLU_REG_LOGIC);
    wire hit_route_w = (paddr_in == `OLU_REG_ROUTE);
    wire hit_stat_w = (paddr_in == `OLU_REG_STATUS);
    wire [`OLU_ADDR_W-1:0] doff_w = paddr_in - `OLU_REG_DLY0;
    wire hit_dly_w = (paddr_in >= `OLU_REG_DLY0) &
        (paddr_in < `OLU_REG_STATUS) & (paddr_in[1:0] == 2'h0);
    wire [2:0] didx_w = doff_w[4:2];
    wire cfg_hit_w = hit_logic_w | hit_route_w | hit_dly_w;
    wire mapped_w = cfg_hit_w | hit_stat_w;
    // Configuration is frozen while running so a live output never
    // sees its source or timing change under it.
    wire refuse_w = pwrite_in & (run_active_in | hit_stat_w);
    wire cfg_we_w = wr_w & cfg_hit_w & ~run_active_in;
    wire [`OLU_DLY_W-1:0] wdly_w = (pwdata_in > 32'(`OLU_DLY_MAX)) ?
        `OLU_DLY_MAX : pwdata_in[`OLU_DLY_W-1:0];

    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & (~mapped_w | refuse_w);
    assign prdata_out = prdata_q;

    // ============================================================
    // Combiner
    wire [`OLU_NUM_FUNC-1:0] fl_w = func_flags_in;
    // Codes beyond the nine functions select a constant low.
    wire in_a_w = (sel_a_q < `OLU_SEL_W'(`OLU_NUM_FUNC)) ?
        fl_w[sel_a_q] : 1'b0;
    wire in_b_w = (sel_b_q < `OLU_SEL_W'(`OLU_NUM_FUNC)) ?
        fl_w[sel_b_q] : 1'b0;
    logic log_w;
    always_comb begin
        case (olu_pkg::olu_op_t'(op_q))
            olu_pkg::OLU_OP_AND: log_w = in_a_w & in_b_w;
            olu_pkg::OLU_OP_OR: log_w = in_a_w | in_b_w;
            olu_pkg::OLU_OP_XOR: log_w = in_a_w ^ in_b_w;
            default: log_w = 1'b0;
        endcase
    end
    wire [`OLU_NUM_FUNC:0] srcs_w = {log_w, fl_w};

    // ============================================================
    // Trip clear input
    logic tc_prev_q;
    wire tc_rise_w = trip_clear_input_in & ~tc_prev_q;
    wire tc_fall_w = ~trip_clear_input_in & tc_prev_q;
    logic cancel_w;
    logic stop_w;
    logic force_w;
    always_comb begin
        case (tripm_q)
            2'h0: begin
                cancel_w = tc_rise_w;
                stop_w = tc_rise_w & run_active_in;
                force_w = trip_clear_input_in;
            end
            2'h1: begin
                cancel_w = tc_fall_w;
                stop_w = tc_fall_w & run_active_in;
                force_w = trip_clear_input_in;
            end
            2'h2: begin
                cancel_w = tc_rise_w & ~run_active_in;
                stop_w = 1'b0;
                force_w = trip_clear_input_in & ~run_active_in;
            end
            default: begin
                cancel_w = 1'b0;
                stop_w = 1'b0;
                force_w = 1'b0;
            end
        endcase
    end

    // ============================================================
    // Tick and per-output delay stages
    logic tick_w;
    olu_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .tick_out(tick_w)
    );

    logic [`OLU_NUM_OUT-1:0] dly_out_w;
    genvar gi;
    generate
        for (gi = 0; gi < `OLU_NUM_OUT; gi++) begin : g_out
            olu_dly_if ch ();
            wire [`OLU_SEL_W-1:0] rsel_w =
                route_q[gi*`OLU_SEL_W +: `OLU_SEL_W];
            // Route code 9 selects the combined output.
            assign ch.src = (rsel_w <= `OLU_SRC_LOG) ?
                srcs_w[rsel_w] : 1'b0;
            assign ch.force_off = force_w;
            assign ch.on_dly = dly_q[2*gi];
            assign ch.off_dly = dly_q[2*gi+1];
            assign ch.tick = tick_w;
            assign dly_out_w[gi] = ch.out;
            olu_delay u_dly (
                .ref_clk_in(ref_clk_in),
                .reset_in(reset_in),
                .ce_in(ce_in),
                .ch(ch)
            );
        end
    endgenerate

    // ============================================================
    // Status word and register read-back mux
    wire [31:0] stat_w = {26'h0, trip_clear_input_in, run_active_in,
        log_w, dly_out_w};
    wire [31:0] logic_rd_w = {20'h0, tripm_q, op_q, sel_b_q, sel_a_q};
    wire [31:0] route_rd_w = {20'h0, route_q};
    wire [31:0] dly_rd_w = {22'h0, dly_q[didx_w]};
    wire [31:0] rd_w = hit_logic_w ? logic_rd_w :
        hit_route_w ? route_rd_w :
        hit_dly_w ? dly_rd_w :
        hit_stat_w ? stat_w : 32'h0;

    // ============================================================
    // Registers
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sel_a_q <= `OLU_SEL_A_RST;
            sel_b_q <= `OLU_SEL_B_RST;
            op_q <= `OLU_OP_RST;
            tripm_q <= `OLU_TRIPM_RST;
            route_q <= `OLU_ROUTE_RST;
        end else if (cfg_we_w & hit_logic_w) begin
            sel_a_q <= pwdata_in[`OLU_SEL_A_LSB +: `OLU_SEL_W];
            sel_b_q <= pwdata_in[`OLU_SEL_B_LSB +: `OLU_SEL_W];
            op_q <= pwdata_in[`OLU_OP_LSB +: 2];
            tripm_q <= pwdata_in[`OLU_TRIPM_LSB +: 2];
        end else if (cfg_we_w & hit_route_w) begin
            route_q <= pwdata_in[3*`OLU_SEL_W-1:0];
        end
    end

    generate
        for (gi = 0; gi < `OLU_DLY_REGS; gi++) begin : g_dreg
            always_ff @(posedge ref_clk_in) begin
                if (reset_in) begin
                    dly_q[gi] <= `OLU_DLY_RST;
                end else if (cfg_we_w & hit_dly_w &
                             (didx_w == 3'(gi))) begin
                    dly_q[gi] <= wdly_w;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            prdata_q <= 32'h0;
            tc_prev_q <= 1'b0;
            term_out <= '0;
            log_out <= 1'b0;
            motor_off_out <= 1'b0;
            trip_cancel_out <= 1'b0;
            drive_stop_out <= 1'b0;
        end else if (ce_in) begin
            if (setup_w & ~pwrite_in) begin
                prdata_q <= rd_w;
            end
            tc_prev_q <= trip_clear_input_in;
            term_out <= dly_out_w;
            log_out <= log_w;
            motor_off_out <= force_w;
            trip_cancel_out <= cancel_w;
            drive_stop_out <= stop_w;
        end
    end
endmodule // olu_top
`default_nettype wire

// ==== sim/olu_props.sv ====
// Purpose: Port assertions for the output logic and delay unit.
// Assumes: ce_in held high; settings shadowed from accepted APB writes.
// Notes: The shadow lets the combiner be checked against its cause.
`default_nettype none
`include "olu_defs.svh"
module olu_props (
    // Clock and bus
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [`OLU_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pslverr_out,
    // Drive side
    input wire logic [`OLU_NUM_FUNC-1:0] func_flags_in,
    input wire logic run_active_in,
    input wire logic trip_clear_input_in,
    input wire logic [`OLU_NUM_OUT-1:0] term_out,
    input wire logic log_out,
    input wire logic trip_cancel_out,
    input wire logic drive_stop_out
);
    // ============================================================
    // Shadow of accepted settings
    logic [11:0] cfg_q;
    logic [2:0] offnz_q;
    wire logic wr_ok = psel_in && penable_in && pwrite_in && !run_active_in;
    wire logic off_wr = paddr_in[2:0] == 3'h4 && paddr_in >= 8'h0C &&
        paddr_in <= 8'h1C;
    wire logic [1:0] oidx = 2'((paddr_in - 8'h0C) >> 3);
    wire logic [1:0] mode = cfg_q[11:10];
    wire logic [1:0] op = cfg_q[9:8];
    wire logic a_v = cfg_q[3:0] < 4'h9 && func_flags_in[cfg_q[3:0]];
    wire logic b_v = cfg_q[7:4] < 4'h9 && func_flags_in[cfg_q[7:4]];
    wire logic exp_log = op == 2'h0 ? a_v & b_v :
        op == 2'h1 ? a_v | b_v : op == 2'h2 && (a_v ^ b_v);
    wire logic trip_up = mode == 2'h0 || mode == 2'h2 && !run_active_in;
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cfg_q <= {`OLU_TRIPM_RST, `OLU_OP_RST, `OLU_SEL_B_RST,
                `OLU_SEL_A_RST};
            offnz_q <= 3'h0;
        end else if (wr_ok && paddr_in == `OLU_REG_LOGIC) begin
            cfg_q <= pwdata_in[11:0];
        end else if (wr_ok && off_wr) begin
            offnz_q[oidx] <= |pwdata_in;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // ============================================================
    // Assertions
    lock_err_a:
    assert property (wr_ok == 1'b0 && psel_in && penable_in && pwrite_in
        |-> pslverr_out) else $error("write during run not refused");
    log_match_a:
    assert property (!$past(reset_in) |-> log_out == $past(exp_log))
        else $error("combined output wrong");
    reset_clr_a:
    assert property (disable iff (1'b0) reset_in |=> term_out == 3'h0 &&
        !log_out && !trip_cancel_out) else $error("outputs not cleared");
    cancel_rise_a:
    assert property ($rose(trip_clear_input_in) && trip_up |=>
        trip_cancel_out) else $error("no cancel on rising edge");
    cancel_fall_a:
    assert property ($fell(trip_clear_input_in) && mode == 2'h1 |=>
        trip_cancel_out) else $error("no cancel on falling edge");
    stop_run_a:
    assert property ($rose(trip_clear_input_in) && mode == 2'h0 &&
        run_active_in |=> drive_stop_out) else $error("no stop in run");
    no_stop_a:
    assert property ($rose(trip_clear_input_in) && mode == 2'h2 &&
        run_active_in |=> !drive_stop_out) else $error("stop in mode 2");
    pulse_one_a:
    assert property (trip_cancel_out |=> !trip_cancel_out)
        else $error("cancel pulse too long");
    off_zero_a:
    assert property ($rose(trip_clear_input_in) && mode == 2'h0 &&
        !offnz_q[0] |-> ##[1:4] !term_out[0]) else $error("no forced off");
endmodule // olu_props
bind olu_top olu_props u_props (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pslverr_out(pslverr_out), .func_flags_in(func_flags_in),
    .run_active_in(run_active_in), .term_out(term_out),
    .trip_clear_input_in(trip_clear_input_in), .log_out(log_out),
    .trip_cancel_out(trip_cancel_out), .drive_stop_out(drive_stop_out));
`default_nettype wire

// ==== sim/olu_ext_rx.sv ====
// Purpose: Outside receiver of the discrete outputs.
// Assumes: Outputs are levels sampled on the system clock.
// Notes: Reports each change one cycle late; bench windows allow it.
`default_nettype none
module olu_ext_rx (
    // Clock
    input wire logic ref_clk_in,
    // Outputs seen from outside
    input wire logic [2:0] term_in,
    // Change report
    output logic chg_out,
    output logic [2:0] val_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] last_q = 3'h0;
    always @(posedge ref_clk_in) begin
        chg_out <= term_in !== last_q;
        val_out <= term_in;
        last_q <= term_in;
    end
endmodule // olu_ext_rx
`default_nettype wire

// ==== sim/olu_top_tb.sv ====
// Purpose: Self-checking bench for the output logic and delay unit.
// Assumes: A tick is shortened to TK cycles; ce_in held high.
// Notes: Delay windows carry one tick of slack for the partial tick.
`default_nettype none
`include "olu_defs.svh"
module olu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 20;
    typedef struct packed {logic [2:0] v; int lo; int hi;} olu_tx_t;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic trip = 1'b0, run = 1'b0, pready, pslverr, logo, chg;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [8:0] flags = 9'h000;
    logic [8:0] fv[5] = '{9'h001, 9'h009, 9'h019, 9'h039, 9'h000};
    logic [2:0] tv[5] = '{3'h1, 3'h3, 3'h1, 3'h5, 3'h0};
    logic [2:0] term, rxv;
    logic [32:0] rdq[$];
    olu_tx_t tq[$];
    int cyc = 0, err_count = 0, checks_done = 0, ncan = 0, nstop = 0;
    logic ncan_p, nstop_p, moff;
    always #2.5 clk = ~clk;
    olu_top #(.TICK_CYCLES(`OLU_CNT_W'(TK))) dut (.ref_clk_in(clk),
        .reset_in(rst), .ce_in(1'b1), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .func_flags_in(flags), .run_active_in(run), .term_out(term),
        .trip_clear_input_in(trip), .log_out(logo), .motor_off_out(moff),
        .trip_cancel_out(ncan_p), .drive_stop_out(nstop_p));
    olu_ext_rx rx (.ref_clk_in(clk), .term_in(term), .chg_out(chg),
        .val_out(rxv));
    // ============================================================
    // Compare and bus tasks
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        cmp_val({31'h0, got[32]}, {31'h0, exp[32]});
        cmp_val(got[31:0], exp[31:0]);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] e);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        rdq.push_back(e);
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic exp_term(input logic [2:0] v, input int lo, input int hi);
        tq.push_back('{v, cyc + lo, cyc + hi});
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic lx(input logic x, y, input logic [1:0] op);
        return op == 2'h0 ? x & y : op == 2'h1 ? x | y :
            op == 2'h2 ? x ^ y : 1'b0;
    endfunction
    task automatic stop_test();
        $display("Checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ============================================================
    // Result watcher and timeout
    always @(posedge clk) begin
        olu_tx_t te;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
        if (psel && pen && pready === 1'b1) begin
            cmp_rd({pslverr, pwr ? 32'h0 : prdata}, rdq.pop_front());
        end
        ncan += int'(ncan_p === 1'b1);
        nstop += int'(nstop_p === 1'b1);
        if (chg === 1'b1 && cyc > 4) begin
            if (tq.size() > 0) begin
                te = tq.pop_front();
            end else begin
                te = '{~rxv, 0, -1};
            end
            cmp_val(32'(rxv), 32'(te.v));
            cmp_val(32'(cyc >= te.lo && cyc <= te.hi), 32'h1);
        end
    end
    // ============================================================
    // Main sequence
    initial begin
        int a;
        logic [3:0] b;
        logic [8:0] f;
        void'($urandom(12544));
        tk(2);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, 8'h00, 0, {1'b0, 32'h010});
        for (a = 0; a < 8; a++) apb(0, 8'(4 * a + 4), 0, 33'h0);
        apb(0, 8'h24, 0, {1'b1, 32'h0});
        apb(1, 8'h20, 32'h1, {1'b1, 32'h0});
        apb(1, 8'h04, 32'hFFF, 33'h0);
        for (a = 0; a < 9; a++) begin
            b = 4'($urandom % 9);
            apb(1, 8'h00, {22'h0, 2'(a % 4), b, 4'(a)}, 33'h0);
            repeat (4) begin
                f = 9'($urandom);
                flags <= f;
                tk(2);
                #1;
                cmp_val(32'(logo), 32'(lx(f[a], f[b], 2'(a % 4))));
                @(posedge clk);
            end
        end
        flags <= 9'h000;
        apb(1, 8'h00, 32'h243, 33'h0);
        apb(1, 8'h04, 32'h590, 33'h0);
        for (a = 0; a < 5; a++) begin
            exp_term(tv[a], 1, 8);
            flags <= fv[a];
            tk(12);
        end
        apb(1, 8'h08, 32'h3, 33'h0);
        apb(1, 8'h0C, 32'h2, 33'h0);
        for (a = 0; a < 2; a++) begin
            exp_term(3'h1, 2 * TK, 4 * TK + 4);
            flags <= 9'h001;
            tk(5 * TK);
            exp_term(3'h0, TK, 3 * TK + 4);
            flags <= 9'h000;
            tk(TK / 2);
            flags <= 9'h001;
            tk(TK / 2);
            flags <= 9'h000;
            tk(4 * TK);
        end
        exp_term(3'h1, 2 * TK, 4 * TK + 4);
        flags <= 9'h001;
        tk(5 * TK);
        exp_term(3'h0, 9 * TK, 11 * TK + 6);
        trip <= 1'b1;
        tk(12 * TK);
        cmp_val(32'(moff), 32'h1);
        exp_term(3'h1, 1, 4 * TK + 6);
        trip <= 1'b0;
        tk(5 * TK);
        cmp_val(32'(moff), 32'h0);
        apb(1, 8'h0C, 32'h0, 33'h0);
        exp_term(3'h0, 1, 8);
        trip <= 1'b1;
        tk(10);
        exp_term(3'h1, 1, 4 * TK + 6);
        trip <= 1'b0;
        tk(5 * TK);
        exp_term(3'h0, 1, 8);
        flags <= 9'h000;
        tk(10);
        apb(1, 8'h18, 32'h3E9, 33'h0);
        apb(0, 8'h18, 0, {1'b0, 32'h3E8});
        run <= 1'b1;
        apb(1, 8'h00, 32'hFFF, {1'b1, 32'h0});
        apb(1, 8'h08, 32'h7, {1'b1, 32'h0});
        apb(0, 8'h00, 0, {1'b0, 32'h243});
        apb(0, 8'h08, 0, {1'b0, 32'h3});
        run <= 1'b0;
        for (a = 0; a < 8; a++) begin
            apb(1, 8'h00, {20'h0, 2'(a / 2), 10'h243}, 33'h0);
            ncan = 0;
            nstop = 0;
            run <= 1'(a % 2);
            tk(2);
            trip <= 1'b1;
            tk(6);
            trip <= 1'b0;
            tk(6);
            cmp_val(32'(ncan), 32'(a < 5));
            cmp_val(32'(nstop), 32'(a < 4 && a % 2 == 1));
            run <= 1'b0;
        end
        cmp_val(32'(tq.size()), 32'h0);
        stop_test();
    end
endmodule // olu_top_tb
`default_nettype wire
